// ### core/rstseq_pkg.sv
package rstseq_pkg;
   // Reset request sources, one bit each
   localparam int SRC_POR      = 0;
   localparam int SRC_PIN      = 1;
   localparam int SRC_CMP      = 2;
   localparam int SRC_SW       = 3;
   localparam int SRC_SUPPLY   = 4;
   localparam int SRC_WDOG     = 5;
   localparam int SRC_MCD      = 6;
   localparam int SRC_FLASH    = 7;
   localparam int NUM_SRC      = 8;

   localparam int PORT_W       = 8;
   localparam int PC_W         = 16;
   localparam int DAC_W        = 12;
   localparam int REF_W        = 4;

   localparam logic [PC_W-1:0]   PC_RESET      = 16'h0000;
   localparam logic [PORT_W-1:0] PORT_LATCH_RST = 8'hFF;
   localparam logic [DAC_W-1:0]  DAC_RST       = 12'h000;
   localparam logic [REF_W-1:0]  REF_RST       = 4'h0;
   localparam logic              CLKSEL_INT    = 1'b0;

   // Exit delay after any source, power-on included, is released
   localparam int CLK_MHZ         = 25;
   localparam int T_RST_US        = 50;
   localparam int T_RST_CYC       = T_RST_US * CLK_MHZ;
   localparam int DLY_W           = 12;

   typedef struct packed {
      logic [PORT_W-1:0] latch;
      logic [PORT_W-1:0] open_drain;
      logic [PORT_W-1:0] weak_pullup;
   } rstseq_port_t;

   typedef struct packed {
      rstseq_port_t      port;
      logic [DAC_W-1:0]  dac;
      logic [REF_W-1:0]  vref;
   } rstseq_keep_t;
endpackage

// ### core/rstseq_combine.sv
`timescale 1ns/100ps
// Merges reset requests and flags whether a power-on kind is among them
module rstseq_combine (
   input  wire logic                             clk,
   input  wire logic [rstseq_pkg::NUM_SRC-1:0]   req,
   output logic                                  any_req,
   output logic                                  por_req,
   output logic                                  pin_drive_req,
   output logic [rstseq_pkg::NUM_SRC-1:0]        req_q
);
   always_ff @(posedge clk) begin
      req_q         <= req;
      any_req       <= |req;
      por_req       <= req[rstseq_pkg::SRC_POR];
      pin_drive_req <= req[rstseq_pkg::SRC_POR] | req[rstseq_pkg::SRC_SUPPLY];
   end
endmodule

// ### core/rstseq_top.sv
`timescale 1ns/100ps
// How it works
// - Reset halts the core's instruction execution
// - Registers default; power-on-only bits survive others
// - Port latches one, open-drain, weak pull-ups
// - Interrupts and timers disabled during reset
// - Data RAM never touched by reset
// - Retention keeps ports, DAC, reference except POR
// - POR and supply resets drive pin low
// - Program counter cleared to zero on exit
// - Internal oscillator selected on exit
// - Watchdog enabled and running after exit
// - Eight sources each request reset
// - Fixed 50 us delay before execution resumes
module rstseq_top (
   input  wire logic                              CLK_SYS,
   input  wire logic                              SYS_RST,
   input  wire logic [rstseq_pkg::NUM_SRC-1:0]    RST_REQ,
   input  wire logic                              RETAIN_EN,
   input  wire logic                              RETAIN_EN_WE,
   input  wire logic                              PORT_LOAD,
   input  wire rstseq_pkg::rstseq_keep_t          KEEP_IN,
   output logic                                   CORE_RUN,
   output logic                                   REG_RST,
   output logic                                   POR_REG_RST,
   output logic                                   IRQ_TIMER_EN,
   output logic                                   RAM_RST,
   output logic [rstseq_pkg::PC_W-1:0]            PC_LOAD_VALUE,
   output logic                                   PC_LOAD,
   output logic                                   CLKSEL_DEFAULT,
   output logic                                   CLKSEL_FORCE,
   output logic                                   WDOG_EN,
   output logic                                   RESET_PIN_N_OUT,
   output logic                                   RESET_PIN_N_OE,
   output logic                                   RETAIN_STATE,
   output rstseq_pkg::rstseq_keep_t               KEEP_OUT,
   output logic [rstseq_pkg::NUM_SRC-1:0]         RST_CAUSE
);
   typedef enum logic [1:0] {ST_RESET, ST_WAIT, ST_RUN} rstseq_state_t;

   localparam logic [rstseq_pkg::DLY_W-1:0] DLY_LAST =
      rstseq_pkg::DLY_W'(rstseq_pkg::T_RST_CYC - 1);

   rstseq_state_t                   state;
   rstseq_state_t                   next_state;
   logic [rstseq_pkg::DLY_W-1:0]    dly;
   logic                            any_req;
   logic                            por_req;
   logic                            pin_drive_req;
   logic [rstseq_pkg::NUM_SRC-1:0]  req_q;
   logic                            por_seen;
   logic                            retain;
   logic                            in_reset;
   logic                            leaving;

   rstseq_combine u_combine (
      .clk           (CLK_SYS),
      .req           (RST_REQ),
      .any_req       (any_req),
      .por_req       (por_req),
      .pin_drive_req (pin_drive_req),
      .req_q         (req_q)
   );

   assign in_reset = SYS_RST | any_req;
   assign leaving  = (state == ST_WAIT) && (dly == DLY_LAST) && !in_reset;

   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: if (!in_reset) next_state = ST_WAIT;
         ST_WAIT:  begin
            if (in_reset) next_state = ST_RESET;
            else if (dly == DLY_LAST) next_state = ST_RUN;
         end
         ST_RUN:   if (in_reset) next_state = ST_RESET;
         default:  next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) state <= ST_RESET;
      else state <= next_state;
   end

   // Delay counts only while waiting; any new request restarts it
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || state != ST_WAIT || in_reset) dly <= '0;
      else if (dly != DLY_LAST) dly <= dly + 1'b1;
   end

   // Power-on kind of reset: remembered until the sequence ends
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) por_seen <= 1'b1;
      else if (por_req) por_seen <= 1'b1;
      else if (state == ST_RUN) por_seen <= 1'b0;
   end

   // Retention enable is itself a power-on-only bit
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || por_req) retain <= 1'b0;
      else if (RETAIN_EN_WE) retain <= RETAIN_EN;
   end

   // Cause capture: sticky while in reset, new sources added
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) RST_CAUSE <= 8'h01;
      else if (state == ST_RUN && any_req) RST_CAUSE <= req_q;
      else if (state != ST_RUN) RST_CAUSE <= RST_CAUSE | req_q;
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         CORE_RUN     <= 1'b0;
         REG_RST      <= 1'b1;
         POR_REG_RST  <= 1'b1;
         IRQ_TIMER_EN <= 1'b0;
      end else begin
         CORE_RUN     <= (state == ST_RUN || leaving) && !in_reset;
         REG_RST      <= (state != ST_RUN || in_reset) && !leaving;
         POR_REG_RST  <= por_req || (por_seen && state != ST_RUN && !leaving);
         IRQ_TIMER_EN <= (state == ST_RUN || leaving) && !in_reset;
      end
   end

   // RAM is never cleared by any reset
   always_ff @(posedge CLK_SYS) begin
      RAM_RST <= 1'b0;
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         PC_LOAD        <= 1'b1;
         PC_LOAD_VALUE  <= rstseq_pkg::PC_RESET;
         CLKSEL_FORCE   <= 1'b1;
         CLKSEL_DEFAULT <= rstseq_pkg::CLKSEL_INT;
         WDOG_EN        <= 1'b0;
      end else begin
         // Same terms as CORE_RUN, so no cycle runs on a stale counter or clock
         PC_LOAD        <= !((state == ST_RUN || leaving) && !in_reset);
         PC_LOAD_VALUE  <= rstseq_pkg::PC_RESET;
         CLKSEL_FORCE   <= !((state == ST_RUN || leaving) && !in_reset);
         CLKSEL_DEFAULT <= rstseq_pkg::CLKSEL_INT;
         WDOG_EN        <= (state == ST_RUN || leaving) && !in_reset;
      end
   end

   // Open-drain pin: output is always low, enable pulls it
   always_ff @(posedge CLK_SYS) begin
      RESET_PIN_N_OUT <= 1'b0;
      if (SYS_RST) RESET_PIN_N_OE <= 1'b1;
      else RESET_PIN_N_OE <= pin_drive_req || (por_seen && state != ST_RUN && !leaving);
   end

   // Retained outputs: held through non-power-on resets when enabled
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || por_req) begin
         KEEP_OUT.port.latch       <= rstseq_pkg::PORT_LATCH_RST;
         KEEP_OUT.port.open_drain  <= rstseq_pkg::PORT_LATCH_RST;
         KEEP_OUT.port.weak_pullup <= rstseq_pkg::PORT_LATCH_RST;
         KEEP_OUT.dac              <= rstseq_pkg::DAC_RST;
         KEEP_OUT.vref             <= rstseq_pkg::REF_RST;
      end else if (in_reset || state != ST_RUN) begin
         if (!retain) begin
            KEEP_OUT.port.latch       <= rstseq_pkg::PORT_LATCH_RST;
            KEEP_OUT.port.open_drain  <= rstseq_pkg::PORT_LATCH_RST;
            KEEP_OUT.port.weak_pullup <= rstseq_pkg::PORT_LATCH_RST;
            KEEP_OUT.dac              <= rstseq_pkg::DAC_RST;
            KEEP_OUT.vref             <= rstseq_pkg::REF_RST;
         end
      end else if (PORT_LOAD) begin
         KEEP_OUT <= KEEP_IN;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) RETAIN_STATE <= 1'b0;
      else RETAIN_STATE <= retain;
   end
endmodule

// ### verif/rstseq_props.sv
`timescale 1ns/100ps
module rstseq_props (
   input wire logic                       CLK_SYS,
   input wire logic                       SYS_RST,
   input wire logic [7:0]                 RST_REQ,
   input wire logic                       CORE_RUN,
   input wire logic                       REG_RST,
   input wire logic                       POR_REG_RST,
   input wire logic                       IRQ_TIMER_EN,
   input wire logic                       WDOG_EN,
   input wire logic                       RAM_RST,
   input wire logic                       PC_LOAD,
   input wire logic [15:0]                PC_LOAD_VALUE,
   input wire logic                       CLKSEL_DEFAULT,
   input wire logic                       RESET_PIN_N_OUT,
   input wire logic                       RESET_PIN_N_OE,
   input wire logic                       RETAIN_STATE,
   input wire rstseq_pkg::rstseq_keep_t   KEEP_OUT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   int idle;
   // Saturates so a long run never wraps
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || (|RST_REQ)) idle <= 0;
      else if (idle < 4000) idle <= idle + 1;
   end
   a_req_halts: assert property (|RST_REQ |-> ##2 !CORE_RUN && REG_RST && !IRQ_TIMER_EN)
      else $error("request did not halt the core");
   a_exit_delay: assert property ($rose(CORE_RUN) |-> idle >= rstseq_pkg::T_RST_CYC)
      else $error("core ran too early");
   a_exit_bound: assert property (idle == rstseq_pkg::T_RST_CYC + 8 |-> CORE_RUN)
      else $error("core never resumed");
   a_run_state: assert property (CORE_RUN |-> WDOG_EN && IRQ_TIMER_EN && !REG_RST && !PC_LOAD)
      else $error("run state outputs wrong");
   a_exit_vector: assert property (!CORE_RUN |-> PC_LOAD && PC_LOAD_VALUE == 16'h0000 && !CLKSEL_DEFAULT)
      else $error("exit vector or clock wrong");
   a_pin_low: assert property (RST_REQ[0] || RST_REQ[4] |-> ##2 RESET_PIN_N_OE && !RESET_PIN_N_OUT)
      else $error("pin not driven low");
   a_pin_free: assert property (CORE_RUN && $past(CORE_RUN) |-> !RESET_PIN_N_OE)
      else $error("pin driven while running");
   a_port_dflt: assert property (POR_REG_RST && $past(POR_REG_RST) |-> KEEP_OUT.port == {3{8'hFF}})
      else $error("port default wrong");
   a_por_clear: assert property (RST_REQ[0] |-> ##3 !RETAIN_STATE && KEEP_OUT.dac == 12'h000)
      else $error("power-on did not clear retention");
   a_keep_hold: assert property (RETAIN_STATE && !CORE_RUN && !POR_REG_RST |-> $stable(KEEP_OUT))
      else $error("retained state moved");
   a_ram_kept: assert property (RAM_RST == 1'b0)
      else $error("ram reset asserted");
   c_exit: cover property ($rose(CORE_RUN));
   c_pin: cover property (RESET_PIN_N_OE && !POR_REG_RST);
   c_keep: cover property ($fell(CORE_RUN) && RETAIN_STATE);
endmodule
bind rstseq_top rstseq_props u_props (.*);

// ### verif/rstseq_src_model.sv
`timescale 1ns/100ps
// Reset pin and on-chip sources, level requests
module rstseq_src_model (
   input  wire logic    clk,
   output logic [7:0]   req
);
   initial req = 8'h00;
   task automatic pulse(input int src, input int cycles);
      @(negedge clk);
      req[src] = 1'h1;
      repeat (cycles) @(negedge clk);
      req[src] = 1'h0;
   endtask
endmodule

// ### verif/system_reset_sequencer_bench.sv
`timescale 1ns/100ps
module system_reset_sequencer_bench;
   // Ports share the design's names so the instance binds by name
   logic CLK_SYS = 1'h0, SYS_RST = 1'h1, RETAIN_EN = 1'h0, RETAIN_EN_WE = 1'h0, PORT_LOAD = 1'h0;
   logic CORE_RUN, REG_RST, POR_REG_RST, IRQ_TIMER_EN, RAM_RST, PC_LOAD, CLKSEL_DEFAULT;
   logic CLKSEL_FORCE, WDOG_EN, RESET_PIN_N_OUT, RESET_PIN_N_OE, RETAIN_STATE;
   logic [7:0]                RST_REQ, RST_CAUSE;
   logic [15:0]               PC_LOAD_VALUE;
   rstseq_pkg::rstseq_keep_t  KEEP_IN = 40'h0, KEEP_OUT;
   localparam logic [39:0]    DFLT = {24'hFFFFFF, 16'h0000};
   localparam logic [39:0]    PAT = 40'hA55A3C1239;
   int fails = 0;
   int tests_run = 0;
   int n;
   rstseq_top u_rstseq_top (.*);
   rstseq_src_model u_rstseq_src_model (.clk(CLK_SYS), .req(RST_REQ));
   initial forever #20 CLK_SYS = ~CLK_SYS;
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wait_run;
      n = 0;
      while (CORE_RUN !== 1'h1 && n < 2000) begin
         @(negedge CLK_SYS);
         n++;
      end
      check("delay", n >= 1250 && n <= 1260, 1);
   endtask
   task load(input logic [39:0] v, input logic ret);
      @(negedge CLK_SYS);
      {KEEP_IN, RETAIN_EN, RETAIN_EN_WE, PORT_LOAD} = {v, ret, 2'h3};
      @(negedge CLK_SYS);
      {RETAIN_EN_WE, PORT_LOAD} = 2'h0;
      @(negedge CLK_SYS);
      check("loaded", {RETAIN_STATE, KEEP_OUT}, {ret, v});
   endtask
   task s_power_up;
      check("por", {CORE_RUN, RESET_PIN_N_OE, RST_CAUSE, KEEP_OUT}, {2'h1, 8'h01, DFLT});
      SYS_RST = 1'h0;
      wait_run();
      check("run", {WDOG_EN, CLKSEL_DEFAULT, CLKSEL_FORCE, PC_LOAD_VALUE, RESET_PIN_N_OE}, 20'h80000);
   endtask
   task s_sources;
      for (int s = 0; s < 8; s++) begin
         u_rstseq_src_model.pulse(s, 3);
         check("halt", {CORE_RUN, IRQ_TIMER_EN, PC_LOAD, CLKSEL_FORCE, RESET_PIN_N_OE}, {4'h3, s == 0 || s == 4});
         wait_run();
         check("cause", RST_CAUSE, 8'h01 << s);
      end
   endtask
   task s_retain;
      load(PAT, 1'h1);
      u_rstseq_src_model.pulse(1, 4);
      check("kept", KEEP_OUT, PAT);
      wait_run();
      check("kept_run", KEEP_OUT, PAT);
      // Retention write while power-on is pending must be refused
      fork
         u_rstseq_src_model.pulse(0, 5);
         begin
            repeat (2) @(negedge CLK_SYS);
            {RETAIN_EN, RETAIN_EN_WE} = 2'h3;
            @(negedge CLK_SYS);
            RETAIN_EN_WE = 1'h0;
         end
      join
      wait_run();
      check("por_clr", {RETAIN_STATE, KEEP_OUT}, {1'h0, DFLT});
      load(PAT, 1'h0);
      u_rstseq_src_model.pulse(2, 3);
      wait_run();
      check("dflt", KEEP_OUT, DFLT);
   endtask
   task s_restart;
      u_rstseq_src_model.pulse(5, 2);
      repeat (600) @(negedge CLK_SYS);
      check("waiting", CORE_RUN, 1'h0);
      u_rstseq_src_model.pulse(6, 2);
      wait_run();
      check("accum", RST_CAUSE, 8'h60);
   endtask
   initial begin
      repeat (5) @(negedge CLK_SYS);
      s_power_up();
      s_sources();
      s_retain();
      s_restart();
      stop_test();
   end
   // Thirteen exit delays are expected
   initial begin
      #1200000;
      fails++;
      stop_test();
   end
endmodule
